// >>> design/mic_irq_ctrl.v
`timescale 1ns/10ps
`default_nettype none
`include "mic_defs.vh"
module mic_irq_ctrl (
    input  wire        CLK,
    input  wire        NRST,
    input  wire        AWVALID,
    output wire        AWREADY,
    input  wire [7:0]  AWADDR,
    input  wire        WVALID,
    output wire        WREADY,
    input  wire [31:0] WDATA,
    input  wire [3:0]  WSTRB,
    output wire        BVALID,
    input  wire        BREADY,
    output wire [1:0]  BRESP,
    input  wire        ARVALID,
    output wire        ARREADY,
    input  wire [7:0]  ARADDR,
    output wire        RVALID,
    input  wire        RREADY,
    output wire [31:0] RDATA,
    output wire [1:0]  RRESP,
    input  wire [7:0]  SRC_REQ,
    input  wire        NMI_REQ,
    input  wire        WDT_REQ,
    input  wire        DBC_REQ,
    input  wire        STEP_REQ,
    input  wire        AMATCH_REQ,
    input  wire        SWI_REQ,
    input  wire [5:0]  SWI_NUM,
    input  wire        INSTR_DONE,
    input  wire        BLOCK_OP_ACTIVE,
    input  wire [19:0] CPU_PC,
    input  wire        SP_ODD,
    input  wire        BUS_8BIT,
    output wire        SUSPEND,
    output wire        ENTRY_BUSY,
    output wire        ENTRY_DONE,
    output wire [2:0]  ENTRY_KIND,
    output wire [19:0] VECTOR_ADDR,
    output wire        VECTOR_FIXED,
    output wire        STACK_WR,
    output wire        STACK_BYTE,
    output wire [15:0] STACK_DATA
);
localparam ST_IDLE  = 2'b01;
localparam ST_ENTRY = 2'b10;
integer i;
reg  [1:0]  st_r;
reg  [11:0] flag_r;
reg  [11:0] flag_nxt;
reg  [11:0] temp_r;
reg  [19:0] vbase_r;
reg  [19:0] vec_r;
reg         vfix_r;
reg  [2:0]  kind_r;
reg  [2:0]  alvl_r;
reg  [5:0]  anum_r;
reg  [19:0] pc_r;
reg         spo_r;
reg  [4:0]  tot_r;
reg  [4:0]  step_r;
reg         done_r;
reg         susp_r;
reg         swr_r;
reg  [15:0] sdat_r;
reg         nmi_p_r, wdt_p_r, dbc_p_r, stp_p_r, am_p_r, swi_p_r;
reg  [5:0]  swn_r;
reg  [5:0]  wait_r;
reg         ovr_r;
reg         awh_r, wh_r, bv_r, rv_r;
reg  [7:0]  awa_r;
reg  [31:0] wd_r;
reg  [3:0]  ws_r;
reg  [1:0]  br_r, rr_r;
reg  [31:0] rd_r;
wire [7:0]  req_w;
wire [23:0] lvl_w;
reg  [7:0]  elig;
reg  [2:0]  best_lvl;
reg  [2:0]  best_idx;
reg         best_ok;
reg  [31:0] rmux;
reg         rmap;
////////////////////////////////////////////////////////////////////////////////
// Bus handshakes
assign AWREADY = ~awh_r & ~bv_r;
assign WREADY  = ~wh_r & ~bv_r;
assign ARREADY = ~rv_r;
assign BVALID  = bv_r;
assign BRESP   = br_r;
assign RVALID  = rv_r;
assign RDATA   = rd_r;
assign RRESP   = rr_r;
wire        do_wr = awh_r & wh_r & ~bv_r;
wire        do_rd = ARVALID & ~rv_r;
wire [31:0] wmask = {{8{ws_r[3]}}, {8{ws_r[2]}}, {8{ws_r[1]}}, {8{ws_r[0]}}};
wire        ctl_sel = (awa_r[7:5] == `MIC_CTRL_PAGE) & (awa_r[1:0] == 2'b00);
wire        wr_flag = do_wr & (awa_r == `MIC_OFF_FLAG);
wire        wr_vb   = do_wr & (awa_r == `MIC_OFF_VBASE);
wire        wr_st   = do_wr & (awa_r == `MIC_OFF_STAT) & ws_r[0];
wire        wmap    = ctl_sel | (awa_r == `MIC_OFF_FLAG) | (awa_r == `MIC_OFF_VBASE)
                    | (awa_r == `MIC_OFF_STAT) | (awa_r == `MIC_OFF_TEMP)
                    | (awa_r == `MIC_OFF_INFO);
wire [31:0] fmerge  = ({20'h00000, flag_r} & ~wmask) | (wd_r & wmask);
wire [31:0] vmerge  = ({12'h000, vbase_r} & ~wmask) | (wd_r & wmask);
////////////////////////////////////////////////////////////////////////////////
// Resolution of maskable requests
wire [2:0] processor_priority_threshold = flag_r[`MIC_FLG_IPL];
always @* begin
    best_lvl = 3'h0;
    best_idx = 3'h0;
    best_ok  = 1'b0;
    for (i = 0; i < 8; i = i + 1) begin
        elig[i] = flag_r[`MIC_FLG_I] & req_w[i] & (lvl_w[i*3 +: 3] > processor_priority_threshold);
        if (elig[i] && (!best_ok || lvl_w[i*3 +: 3] > best_lvl)) begin
            best_lvl = lvl_w[i*3 +: 3];
            best_idx = i[2:0];
            best_ok  = 1'b1;
        end
    end
end
wire [5:0] best_num = `MIC_NUM_BASE + {3'h0, best_idx};
////////////////////////////////////////////////////////////////////////////////
// Acceptance
wire idle     = st_r[0];
wire boundary = INSTR_DONE | BLOCK_OP_ACTIVE;
wire any_pend = nmi_p_r | dbc_p_r | wdt_p_r | best_ok | stp_p_r | am_p_r | swi_p_r;
wire accept   = idle & boundary & any_pend;
reg  [2:0] k;
always @* begin
    if (nmi_p_r)      k = `MIC_K_NMI;
    else if (dbc_p_r) k = `MIC_K_DBC;
    else if (wdt_p_r) k = `MIC_K_WDT;
    else if (best_ok) k = `MIC_K_MASK;
    else if (stp_p_r) k = `MIC_K_STEP;
    else if (am_p_r)  k = `MIC_K_AM;
    else              k = `MIC_K_SWI;
end
wire        k_var  = (k == `MIC_K_MASK) | (k == `MIC_K_SWI);
wire [5:0]  k_num  = (k == `MIC_K_MASK) ? best_num : swn_r;
wire [19:0] k_vec  = vbase_r + {12'h000, k_num, 2'b00};
wire        k_vodd = k_var & vbase_r[0];
wire [4:0]  k_ext  = (k == `MIC_K_DBC) ? `MIC_EXT_DBC :
                     ((k == `MIC_K_STEP) | (k == `MIC_K_AM)) ? `MIC_EXT_DBG : 5'h00;
wire [4:0]  k_base = BUS_8BIT ? `MIC_ENT_8 :
                     (`MIC_ENT_16 + {4'h0, k_vodd} + {4'h0, SP_ODD});
wire info_rd  = do_rd & (ARADDR == `MIC_OFF_INFO) & best_ok;
wire seq_clr  = accept & (k == `MIC_K_MASK);
wire last     = st_r[1] & (step_r == tot_r - 5'h01);
wire [4:0] nwr = spo_r ? `MIC_WR_BYTE : `MIC_WR_WORD;
////////////////////////////////////////////////////////////////////////////////
// Per-source control registers
genvar g;
generate
    for (g = 0; g < 8; g = g + 1) begin : src
        reg  [2:0] lvl_r;
        reg        req_r;
        wire       cw  = do_wr & ctl_sel & (awa_r[4:2] == g) & ws_r[0];
        wire       clr = (cw & ~wd_r[`MIC_CTL_REQ])
                       | ((info_rd | seq_clr) & (best_idx == g));
        always @(posedge CLK or negedge NRST) begin
            if (!NRST) begin
                lvl_r <= 3'h0;
                req_r <= 1'b0;
            end else begin
                if (SRC_REQ[g])
                    req_r <= 1'b1;
                else if (clr)
                    req_r <= 1'b0;
                if (cw)
                    lvl_r <= wd_r[`MIC_CTL_LVL];
            end
        end
        assign req_w[g] = req_r;
        assign lvl_w[g*3 +: 3] = lvl_r;
    end
endgenerate
////////////////////////////////////////////////////////////////////////////////
// Flag word
always @* begin
    flag_nxt = wr_flag ? fmerge[11:0] : flag_r;
    if (accept) begin
        flag_nxt[`MIC_FLG_I] = 1'b0;
        flag_nxt[`MIC_FLG_D] = 1'b0;
        if (!((k == `MIC_K_SWI) && (swn_r >= `MIC_SWI_ULO)))
            flag_nxt[`MIC_FLG_U] = 1'b0;
    end
    if (last) begin
        if (kind_r == `MIC_K_MASK)
            flag_nxt[`MIC_FLG_IPL] = alvl_r;
        else if ((kind_r == `MIC_K_NMI) || (kind_r == `MIC_K_WDT))
            flag_nxt[`MIC_FLG_IPL] = `MIC_LVL_TOP;
    end
end
always @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
        flag_r  <= `MIC_FLG_RST;
        temp_r  <= 12'h000;
        vbase_r <= 20'h00000;
    end else begin
        flag_r <= flag_nxt;
        if (accept)
            temp_r <= flag_r;
        if (wr_vb)
            vbase_r <= vmerge[19:0];
    end
end
////////////////////////////////////////////////////////////////////////////////
// Special sources, latency watch
always @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
        nmi_p_r <= 1'b0;
        wdt_p_r <= 1'b0;
        dbc_p_r <= 1'b0;
        stp_p_r <= 1'b0;
        am_p_r  <= 1'b0;
        swi_p_r <= 1'b0;
        swn_r   <= 6'h00;
        wait_r  <= 6'h00;
        ovr_r   <= 1'b0;
    end else begin
        nmi_p_r <= NMI_REQ    | (nmi_p_r & ~(accept & (k == `MIC_K_NMI)));
        wdt_p_r <= WDT_REQ    | (wdt_p_r & ~(accept & (k == `MIC_K_WDT)));
        dbc_p_r <= DBC_REQ    | (dbc_p_r & ~(accept & (k == `MIC_K_DBC)));
        stp_p_r <= STEP_REQ   | (stp_p_r & ~(accept & (k == `MIC_K_STEP)));
        am_p_r  <= AMATCH_REQ | (am_p_r  & ~(accept & (k == `MIC_K_AM)));
        if (SWI_REQ & ~swi_p_r) begin
            swi_p_r <= 1'b1;
            swn_r   <= SWI_NUM;
        end else if (accept & (k == `MIC_K_SWI)) begin
            swi_p_r <= 1'b0;
        end
        if (idle & any_pend & ~boundary) begin
            if (wait_r != `MIC_MAX_WAIT)
                wait_r <= wait_r + 6'h01;
        end else begin
            wait_r <= 6'h00;
        end
        if (idle & any_pend & ~boundary & (wait_r == `MIC_MAX_WAIT))
            ovr_r <= 1'b1;
        else if (wr_st & wd_r[0])
            ovr_r <= 1'b0;
    end
end
////////////////////////////////////////////////////////////////////////////////
// Entry sequencer
wire [15:0] w0  = {pc_r[19:16], temp_r};
wire [15:0] w1  = pc_r[15:0];
wire        sel = spo_r ? step_r[1] : step_r[0];
wire [15:0] wsel = sel ? w1 : w0;
always @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
        st_r   <= ST_IDLE;
        step_r <= 5'h00;
        tot_r  <= `MIC_ENT_16;
        kind_r <= `MIC_K_MASK;
        alvl_r <= 3'h0;
        anum_r <= 6'h00;
        vec_r  <= 20'h00000;
        vfix_r <= 1'b0;
        pc_r   <= 20'h00000;
        spo_r  <= 1'b0;
        done_r <= 1'b0;
        susp_r <= 1'b0;
        swr_r  <= 1'b0;
        sdat_r <= 16'h0000;
    end else begin
        done_r <= 1'b0;
        susp_r <= 1'b0;
        swr_r  <= 1'b0;
        case (st_r)
            ST_IDLE: begin
                if (accept) begin
                    st_r   <= ST_ENTRY;
                    susp_r <= ~INSTR_DONE;
                    step_r <= 5'h00;
                    tot_r  <= k_base + k_ext;
                    kind_r <= k;
                    alvl_r <= best_lvl;
                    anum_r <= k_num;
                    vec_r  <= k_var ? k_vec : 20'h00000;
                    vfix_r <= ~k_var;
                    pc_r   <= CPU_PC;
                    spo_r  <= SP_ODD;
                end
            end
            ST_ENTRY: begin
                step_r <= step_r + 5'h01;
                if (step_r < nwr) begin
                    swr_r  <= 1'b1;
                    sdat_r <= spo_r ? {8'h00, step_r[0] ? wsel[15:8] : wsel[7:0]} : wsel;
                end
                if (last) begin
                    st_r   <= ST_IDLE;
                    done_r <= 1'b1;
                end
            end
            default: st_r <= ST_IDLE;
        endcase
    end
end
assign SUSPEND      = susp_r;
assign ENTRY_BUSY   = st_r[1];
assign ENTRY_DONE   = done_r;
assign ENTRY_KIND   = kind_r;
assign VECTOR_ADDR  = vec_r;
assign VECTOR_FIXED = vfix_r;
assign STACK_WR     = swr_r;
assign STACK_BYTE   = spo_r;
assign STACK_DATA   = sdat_r;
////////////////////////////////////////////////////////////////////////////////
// Register bus
always @* begin
    rmux = 32'h00000000;
    rmap = 1'b1;
    if (ARADDR[7:5] == `MIC_CTRL_PAGE && ARADDR[1:0] == 2'b00) begin
        rmux = {28'h0000000, req_w[ARADDR[4:2]], lvl_w[ARADDR[4:2]*3 +: 3]};
    end else begin
        case (ARADDR)
            `MIC_OFF_INFO:  rmux = best_ok ? {23'h000000, best_lvl, best_num} : 32'h00000000;
            `MIC_OFF_FLAG:  rmux = {20'h00000, flag_r};
            `MIC_OFF_VBASE: rmux = {12'h000, vbase_r};
            `MIC_OFF_TEMP:  rmux = {20'h00000, temp_r};
            `MIC_OFF_STAT:  rmux = {30'h00000000, st_r[1], ovr_r};
            default:        rmap = 1'b0;
        endcase
    end
end
always @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
        awh_r <= 1'b0;
        wh_r  <= 1'b0;
        bv_r  <= 1'b0;
        rv_r  <= 1'b0;
        awa_r <= 8'h00;
        wd_r  <= 32'h00000000;
        ws_r  <= 4'h0;
        br_r  <= `MIC_OKAY;
        rr_r  <= `MIC_OKAY;
        rd_r  <= 32'h00000000;
    end else begin
        if (AWVALID & ~awh_r & ~bv_r) begin
            awh_r <= 1'b1;
            awa_r <= AWADDR;
        end
        if (WVALID & ~wh_r & ~bv_r) begin
            wh_r <= 1'b1;
            wd_r <= WDATA;
            ws_r <= WSTRB;
        end
        if (do_wr) begin
            awh_r <= 1'b0;
            wh_r  <= 1'b0;
            bv_r  <= 1'b1;
            br_r  <= wmap ? `MIC_OKAY : `MIC_SLVERR;
        end else if (bv_r & BREADY) begin
            bv_r <= 1'b0;
        end
        if (do_rd) begin
            rv_r <= 1'b1;
            rd_r <= rmux;
            rr_r <= rmap ? `MIC_OKAY : `MIC_SLVERR;
        end else if (rv_r & RREADY) begin
            rv_r <= 1'b0;
        end
    end
end
endmodule
`default_nettype wire

// >>> include/mic_defs.vh
`ifndef MIC_DEFS_VH
`define MIC_DEFS_VH
// Register byte offsets
`define MIC_OFF_INFO  8'h00
`define MIC_OFF_FLAG  8'h04
`define MIC_OFF_VBASE 8'h08
`define MIC_OFF_TEMP  8'h0C
`define MIC_OFF_STAT  8'h10
`define MIC_CTRL_PAGE 3'h2
// Flag word fields
`define MIC_FLG_I     0
`define MIC_FLG_D     1
`define MIC_FLG_U     2
`define MIC_FLG_IPL   6:4
`define MIC_FLG_RST   12'h000
// Control register fields
`define MIC_CTL_LVL   2:0
`define MIC_CTL_REQ   3
// Entry timing in cycles
`define MIC_ENT_16    5'h12
`define MIC_ENT_8     5'h14
`define MIC_EXT_DBC   5'h02
`define MIC_EXT_DBG   5'h01
`define MIC_MAX_WAIT  6'h1E
`define MIC_WR_WORD   5'h02
`define MIC_WR_BYTE   5'h04
// Levels and numbers
`define MIC_LVL_TOP   3'h7
`define MIC_SWI_ULO   6'h20
`define MIC_NUM_BASE  6'h15
// Accepted source kinds
`define MIC_K_MASK    3'h0
`define MIC_K_NMI     3'h1
`define MIC_K_DBC     3'h2
`define MIC_K_WDT     3'h3
`define MIC_K_STEP    3'h4
`define MIC_K_AM      3'h5
`define MIC_K_SWI     3'h6
// Bus answers
`define MIC_OKAY      2'h0
`define MIC_SLVERR    2'h2
`endif

// >>> verif/mic_cpu_model.sv
`timescale 1ns/10ps
`default_nettype none
module mic_cpu_model (
    input  wire logic       clk,
    input  wire logic       nrst,
    input  wire logic       run,
    input  wire logic       blk,
    input  wire logic [4:0] gap,
    input  wire logic       busy,
    output logic            instr_done,
    output logic            block_op,
    output logic [19:0]     pc
);
logic [4:0] cnt_r;
////////////////////////////////////////////////////////////////
// Instruction stream, stalled while the entry runs
always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
        cnt_r <= 5'h00;
        instr_done <= 1'b0;
        block_op <= 1'b0;
        pc <= 20'h00000;
    end else begin
        block_op <= blk && !busy;
        instr_done <= 1'b0;
        if (busy || !run) begin
            cnt_r <= 5'h00;
        end else if (cnt_r >= gap) begin
            cnt_r <= 5'h00;
            instr_done <= 1'b1;
            pc <= pc + 20'h00001;
        end else begin
            cnt_r <= cnt_r + 5'h01;
        end
    end
end
endmodule
`default_nettype wire

// >>> verif/mic_irq_props.sv
`timescale 1ns/10ps
`default_nettype none
`include "mic_defs.vh"
module mic_irq_props (
    input wire logic        CLK,
    input wire logic        NRST,
    input wire logic        INSTR_DONE,
    input wire logic        BLOCK_OP_ACTIVE,
    input wire logic        BUS_8BIT,
    input wire logic        SUSPEND,
    input wire logic        ENTRY_BUSY,
    input wire logic        ENTRY_DONE,
    input wire logic [2:0]  ENTRY_KIND,
    input wire logic [19:0] VECTOR_ADDR,
    input wire logic        VECTOR_FIXED,
    input wire logic        STACK_WR,
    input wire logic        STACK_BYTE
);
logic [4:0] bcnt_r;
logic [2:0] wcnt_r;
logic [4:0] exp_t;
default clocking dc @(posedge CLK); endclocking
default disable iff (!NRST);
////////////////////////////////////////////////////////////////
// Busy cycles and stack writes of the running entry
always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
        bcnt_r <= 5'h00;
        wcnt_r <= 3'h0;
    end else begin
        bcnt_r <= ENTRY_BUSY ? bcnt_r + 5'h01 : 5'h00;
        wcnt_r <= ENTRY_BUSY ? wcnt_r + 3'(STACK_WR) : 3'h0;
    end
end
always_comb begin
    exp_t = BUS_8BIT ? `MIC_ENT_8 : `MIC_ENT_16 + 5'(VECTOR_ADDR[0]) + 5'(STACK_BYTE);
    if (ENTRY_KIND == `MIC_K_DBC)
        exp_t = exp_t + `MIC_EXT_DBC;
    if (ENTRY_KIND == `MIC_K_STEP || ENTRY_KIND == `MIC_K_AM)
        exp_t = exp_t + `MIC_EXT_DBG;
end
////////////////////////////////////////////////////////////////
entry_len_a: assert property (ENTRY_DONE |-> bcnt_r == exp_t)
    else $error("entry length wrong");
stack_cnt_a: assert property (ENTRY_DONE |-> wcnt_r == (STACK_BYTE ? 3'h4 : 3'h2))
    else $error("stack write count wrong");
done_end_a: assert property (ENTRY_DONE |-> !ENTRY_BUSY && $past(ENTRY_BUSY))
    else $error("done without entry");
first_push_a: assert property ($rose(ENTRY_BUSY) |=> STACK_WR)
    else $error("first push late");
push_inside_a: assert property (STACK_WR |-> ENTRY_BUSY)
    else $error("push outside entry");
accept_edge_a: assert property ($rose(ENTRY_BUSY) |-> $past(INSTR_DONE || BLOCK_OP_ACTIVE))
    else $error("accept off boundary");
suspend_src_a: assert property (SUSPEND |-> $rose(ENTRY_BUSY) && $past(BLOCK_OP_ACTIVE)
    && !$past(INSTR_DONE))
    else $error("suspend wrong");
fixed_vec_a: assert property (ENTRY_BUSY |->
    VECTOR_FIXED == (ENTRY_KIND != `MIC_K_MASK && ENTRY_KIND != `MIC_K_SWI))
    else $error("vector kind wrong");
cover property ($rose(SUSPEND));
cover property (ENTRY_DONE && STACK_BYTE);
cover property (ENTRY_DONE && ENTRY_KIND == `MIC_K_DBC);
endmodule
bind mic_irq_ctrl mic_irq_props u_props (
    .CLK(CLK), .NRST(NRST), .INSTR_DONE(INSTR_DONE), .BLOCK_OP_ACTIVE(BLOCK_OP_ACTIVE),
    .BUS_8BIT(BUS_8BIT), .SUSPEND(SUSPEND), .ENTRY_BUSY(ENTRY_BUSY), .ENTRY_DONE(ENTRY_DONE),
    .ENTRY_KIND(ENTRY_KIND), .VECTOR_ADDR(VECTOR_ADDR), .VECTOR_FIXED(VECTOR_FIXED),
    .STACK_WR(STACK_WR), .STACK_BYTE(STACK_BYTE)
);
`default_nettype wire

// >>> verif/testbench.sv
`timescale 1ns/10ps
`default_nettype none
`include "mic_defs.vh"
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin fail_count++; \
    $display("wrong value %s expected %0h seen %0h", n, e, g); end end
module testbench;
logic clk = 0, nrst = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
logic sp_odd = 0, bus8 = 0, run = 0, blk = 0, sus_seen = 0;
logic [7:0] awaddr = 0, araddr = 0, src = 0;
logic [31:0] wdata = 0, d;
logic [5:0] pk = 0, swi_num = 0;
logic [4:0] gap = 0;
logic [1:0] r;
wire awready, wready, bvalid, arready, rvalid, idone, bop, suspend, busy, done, vfix, swr, sbyte;
wire [1:0] bresp, rresp;
wire [31:0] rdata;
wire [2:0] kind;
wire [19:0] vaddr, pc;
wire [15:0] sdata;
int fail_count = 0, compares = 0;
always #5 clk = ~clk;
always @(posedge clk) if (suspend) sus_seen <= 1'b1;
logic [15:0] stk [4];
logic [2:0] sn = 0;
logic [19:0] pc_q = 0;
// Stack words of the running entry, and the PC the CPU showed at acceptance
always @(posedge clk) begin
    if (!busy) begin
        sn <= 3'h0;
        pc_q <= pc;
    end else if (swr) begin
        stk[sn[1:0]] <= sdata;
        sn <= sn + 3'h1;
    end
end
mic_irq_ctrl dut (.CLK(clk), .NRST(nrst), .AWVALID(awvalid), .AWREADY(awready),
    .AWADDR(awaddr), .WVALID(wvalid), .WREADY(wready), .WDATA(wdata), .WSTRB(4'hF),
    .BVALID(bvalid), .BREADY(bready), .BRESP(bresp), .ARVALID(arvalid), .ARREADY(arready),
    .ARADDR(araddr), .RVALID(rvalid), .RREADY(rready), .RDATA(rdata), .RRESP(rresp),
    .SRC_REQ(src), .NMI_REQ(pk[0]), .DBC_REQ(pk[1]), .WDT_REQ(pk[2]), .STEP_REQ(pk[3]),
    .AMATCH_REQ(pk[4]), .SWI_REQ(pk[5]), .SWI_NUM(swi_num), .INSTR_DONE(idone),
    .BLOCK_OP_ACTIVE(bop), .CPU_PC(pc), .SP_ODD(sp_odd), .BUS_8BIT(bus8), .SUSPEND(suspend),
    .ENTRY_BUSY(busy), .ENTRY_DONE(done), .ENTRY_KIND(kind), .VECTOR_ADDR(vaddr),
    .VECTOR_FIXED(vfix), .STACK_WR(swr), .STACK_BYTE(sbyte), .STACK_DATA(sdata));
mic_cpu_model cpu (.clk(clk), .nrst(nrst), .run(run), .blk(blk), .gap(gap), .busy(busy),
    .instr_done(idone), .block_op(bop), .pc(pc));
////////////////////////////////////////////////////////////////
task automatic give_verdict;
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
        $display("ALL TESTS PASSED");
    else
        $display("TESTS FAILED");
    $finish;
endtask
task automatic tmo(input int n);
    if (n >= 200) begin
        fail_count++;
        $display("wrong value wait expected 0 seen 1");
        give_verdict;
    end
endtask
task automatic wr(input [7:0] a, input [31:0] v);
    int n;
    logic ta, tw, ga, gw;
    n = 0;
    ga = 0;
    gw = 0;
    @(posedge clk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    while (!(ga && gw)) begin
        @(negedge clk);
        ta = awvalid && awready;
        tw = wvalid && wready;
        @(posedge clk);
        if (ta) awvalid <= 0;
        if (tw) wvalid <= 0;
        ga = ga | ta;
        gw = gw | tw;
        n++;
        tmo(n);
    end
    do begin @(negedge clk); n++; tmo(n); end while (!bvalid);
    r = bresp;
    @(posedge clk);
    bready <= 0;
endtask
task automatic rd(input [7:0] a);
    int n;
    n = 0;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1;
    rready <= 1;
    do begin @(negedge clk); n++; tmo(n); end while (!arready);
    @(posedge clk);
    arvalid <= 0;
    do begin @(negedge clk); n++; tmo(n); end while (!rvalid);
    d = rdata;
    r = rresp;
    @(posedge clk);
    rready <= 0;
endtask
task automatic pulse(input [7:0] m, input [5:0] p);
    @(posedge clk);
    src <= m;
    pk <= p;
    @(posedge clk);
    src <= 0;
    pk <= 0;
endtask
task automatic wait_done;
    int n;
    n = 0;
    do begin @(negedge clk); n++; tmo(n); end while (!done);
endtask
function automatic [8:0] best(input [7:0] q, input [23:0] lv, input [2:0] t, input en);
    best = 0;
    for (int i = 0; i < 8; i++)
        if (en && q[i] && lv[3*i+:3] > t && lv[3*i+:3] > best[8:6])
            best = {lv[3*i+:3], 6'(21 + i)};
endfunction
////////////////////////////////////////////////////////////////
initial begin
    logic [23:0] lv;
    logic [19:0] vb;
    logic [8:0] e;
    logic [7:0] q;
    logic [2:0] t;
    logic en;
    logic [31:0] sv;
    void'($urandom(32'h16876BAB));
    repeat (10) @(posedge clk);
    nrst <= 1;
    rd(`MIC_OFF_FLAG); `CHK("flag", 32'h0, d)
    rd(8'h3C); `CHK("resp", `MIC_SLVERR, r)
    wr(8'h3C, 32'h1); `CHK("bresp", `MIC_SLVERR, r)
    $display("reset test done");
    wr(8'h40, 32'hD); rd(8'h40); `CHK("ctl", 4'h5, d[3:0])
    pulse(8'h01, 0); rd(8'h40); `CHK("ctl", 4'hD, d[3:0])
    rd(`MIC_OFF_FLAG); `CHK("flag", 32'h0, d)
    wr(8'h40, 32'h5); rd(8'h40); `CHK("ctl", 4'h5, d[3:0])
    $display("request bit test done");
    // CPU halted while control registers change
    for (int k = 0; k < 7; k++) begin
        lv = (k == 6) ? 24'h0 : 24'($urandom);
        t = 3'($urandom);
        en = 1'($urandom) | (k < 3);
        q = 8'($urandom);
        for (int i = 0; i < 8; i++) wr(8'h40 + 8'(4 * i), 32'(lv[3*i+:3]));
        wr(`MIC_OFF_FLAG, {25'h0, t, 3'h0, en});
        if (k < 6) begin
            pulse(q, 0);
            repeat (2) begin
                e = best(q, lv, t, en);
                rd(`MIC_OFF_INFO); `CHK("info", e, d[8:0])
                if (e != 0) q[int'(e[5:0]) - 21] = 0;
            end
        end
    end
    $display("priority test done");
    run <= 1;
    for (int k = 0; k < 4; k++) begin
        vb = 20'($urandom);
        gap <= 5'($urandom % 30);
        sp_odd <= k[0];
        bus8 <= k[1];
        wr(`MIC_OFF_VBASE, 32'(vb));
        wr(8'h4C, 32'h6);
        wr(`MIC_OFF_FLAG, 32'h27); `CHK("bresp", `MIC_OKAY, r)
        pulse(8'h08, 0);
        wait_done;
        `CHK("kind", `MIC_K_MASK, kind)
        `CHK("vector", vb + 20'h60, vaddr)
        `CHK("byte", k[0], sbyte)
        sv = k[0] ? {stk[1][7:0], stk[0][7:0], stk[3][7:0], stk[2][7:0]} : {stk[0], stk[1]};
        `CHK("stack", {pc_q[19:16], 12'h027, pc_q[15:0]}, sv)
        rd(`MIC_OFF_FLAG); `CHK("flag", 7'h60, d[6:0])
        rd(`MIC_OFF_TEMP); `CHK("temp", 7'h27, d[6:0])
        rd(8'h4C); `CHK("ctl", 4'h6, d[3:0])
    end
    $display("maskable entry test done");
    for (int j = 0; j < 7; j++) begin
        swi_num <= (j == 5) ? 6'h28 : 6'h0A;
        wr(`MIC_OFF_FLAG, 32'h37);
        pulse(0, 6'h01 << ((j > 5) ? 5 : j));
        wait_done;
        `CHK("kind", 3'(((j > 5) ? 5 : j) + 1), kind)
        rd(`MIC_OFF_FLAG);
        `CHK("flag", {(j == 0 || j == 2) ? 3'h7 : 3'h3, 1'b0, j == 5, 2'h0}, d[6:0])
    end
    $display("fixed source test done");
    run <= 0;
    wr(`MIC_OFF_STAT, 32'h1); rd(`MIC_OFF_STAT); `CHK("stat", 2'h0, d[1:0])
    pulse(0, 6'h01);
    repeat (40) @(posedge clk);
    rd(`MIC_OFF_STAT); `CHK("stat", 2'h1, d[1:0])
    blk <= 1;
    wait_done;
    `CHK("suspend", 1'b1, sus_seen)
    blk <= 0;
    $display("suspend test done");
    give_verdict;
end
endmodule
`default_nettype wire
